// ### rtl/cmwc_map.vh
// controller constants: reset values, mode codes, masks, counts.
// included by bare name; definitions only.
`ifndef CMWC_MAP_VH
`define CMWC_MAP_VH

// control bit reset values: on-chip oscillator divided by 16
`define CMWC_RST_DIV8          1'h0
`define CMWC_RST_MAIN_STOP     1'h0
`define CMWC_RST_SUB_EN        1'h0
`define CMWC_RST_SUB_CPU       1'h0
`define CMWC_RST_ONCHIP_SRC    1'h1
`define CMWC_RST_PLL_CPU       1'h0
`define CMWC_RST_RATIO         2'h3
`define CMWC_RST_WAIT_STOP     1'h0
`define CMWC_RST_WDT_ONCHIP    1'h0
`define CMWC_RST_PLL_RUN       1'h0
`define CMWC_RST_FREQ          4'h0

// cpu divide ratio codes
`define CMWC_RATIO_DIV1        2'h0
`define CMWC_RATIO_DIV2        2'h1
`define CMWC_RATIO_DIV4        2'h2
`define CMWC_RATIO_DIV16       2'h3

// divider masks: divide by n uses mask n-1
`define CMWC_MASK_DIV1         5'h00
`define CMWC_MASK_DIV2         5'h01
`define CMWC_MASK_DIV4         5'h03
`define CMWC_MASK_DIV8         5'h07
`define CMWC_MASK_DIV16        5'h0F
`define CMWC_MASK_DIV32        5'h1F

// bit positions of the one-hot mode output, then its width
`define CMWC_MODE_PLL          0
`define CMWC_MODE_HIGH         1
`define CMWC_MODE_MEDIUM       2
`define CMWC_MODE_LOW          3
`define CMWC_MODE_LOWPWR       4
`define CMWC_MODE_ONCHIP       5
`define CMWC_MODE_ONCHIP_LP    6
`define CMWC_MODE_W            7

// wake source channel counts and port width
`define CMWC_TMR_N             8
`define CMWC_SIO_N             5
`define CMWC_PORT_W            16

`endif

// ### rtl/cmwc_tick_div.v
// cmwc_tick_div: divides a one-cycle source enable by a power of two.
// assumes src_tick_i is a one-cycle core_clk_i enable.
`timescale 1ns/1ns
`include "cmwc_map.vh"

module cmwc_tick_div (
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       src_tick_i,
  input  wire [4:0] mask_i,
  output wire       tick_o
);

  reg  [4:0] cnt_q;
  wire [4:0] cnt_d;

  // free count of source ticks; the mask is applied combinationally, so a change takes effect at once
  assign cnt_d = cnt_q + 5'h01;

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_q <= 5'h00;
    end else if (src_tick_i) begin
      cnt_q <= cnt_d;
    end
  end

  // pass the tick when the masked low bits are all ones
  assign tick_o = src_tick_i & (&(cnt_q | ~mask_i));

endmodule // cmwc_tick_div

// ### rtl/cmwc_clock_ctrl.v
// cmwc_clock_ctrl: clock mode select, clock enables and wait mode.
// assumes oscillator ticks are one-cycle core_clk_i enables, interrupts arrive
// already qualified by priority and global enable, and control writes are a
// one-cycle strobe carrying all fields.
`timescale 1ns/1ns
`include "cmwc_map.vh"

// Function
// (RULE1) low power mode: main oscillator off, cpu on sub clock, only sub tap runs
// (RULE2) main stop write in low-speed enters low power and forces div8 select
// (RULE3) software leaves div8 select alone in low power mode
// (RULE4) on-chip mode: cpu from on-chip oscillator divided 1..16, peripherals too
// (RULE5) on-chip oscillator frequency comes from four-bit select field
// (RULE6) software sets div8 select before leaving on-chip mode for main clock
// (RULE7) on-chip low power: main off, same cpu divides, peripherals from on-chip
// (RULE8) pll, high and medium speed modes decoded from select and ratio bits
// (RULE9) on-chip modes need on-chip select set and sub cpu select clear; the illegal-set fallback also gives on-chip low power without them
// (RULE10) wait stops cpu and watchdog unless watchdog uses on-chip oscillator
// (RULE11) wait with peripheral stop bit gates divided clocks, sub tap keeps running
// (RULE12) wait is entered only by the halt instruction
// (RULE13) software moves cpu off the pll before halting
// (RULE14) port levels held at their pre-wait values during wait
// (RULE15) wait ends on reset, nmi or enabled peripheral interrupt
// (RULE16) software masks peripheral priorities when only reset or nmi should wake
// (RULE17) peripheral stop bit limits wake-ups to externally clocked peripherals
// (RULE18) nmi, key and pin always wake; i2c, timer s, converter only with clocks on
// (RULE19) timers wake always with clocks on, else event mode or sub tap source
// (RULE20) serial wakes with any clocking when clocks on, else external clock only
// (RULE21) software sets priorities, global enable and peripheral before halting
// (RULE22) wake resumes with the same cpu source and divider as before halt
// (RULE23) cpu clock released on a clean edge of the selected source
// (RULE24) illegal control bit sets never pick a stopped oscillator
module cmwc_clock_ctrl (
  input  wire                      core_clk_i,
  input  wire                      srst_i,
  // control write strobe and fields
  input  wire                      cc_wr_i,
  input  wire                      wr_div8_select_i,
  input  wire                      wr_main_osc_stop_i,
  input  wire                      wr_sub_osc_enable_i,
  input  wire                      wr_sub_cpu_source_select_i,
  input  wire                      wr_onchip_source_select_i,
  input  wire                      wr_pll_cpu_select_i,
  input  wire [1:0]                wr_cpu_divide_ratio_i,
  input  wire                      wr_wait_periph_clock_stop_i,
  input  wire                      wr_watchdog_onchip_source_i,
  input  wire                      wr_pll_run_enable_i,
  input  wire [3:0]                wr_onchip_freq_select_i,
  // oscillator ticks
  input  wire                      main_tick_i,
  input  wire                      sub_tick_i,
  input  wire                      onchip_tick_i,
  input  wire                      pll_tick_i,
  // cpu and wake sources
  input  wire                      halt_i,
  input  wire                      nmi_i,
  input  wire                      key_irq_i,
  input  wire                      ext_pin_irq_i,
  input  wire                      i2c_irq_i,
  input  wire                      timer_s_irq_i,
  input  wire                      adc_irq_i,
  input  wire                      adc_single_mode_i,
  input  wire [`CMWC_TMR_N-1:0]    tmr_irq_i,
  input  wire [`CMWC_TMR_N-1:0]    tmr_event_mode_i,
  input  wire [`CMWC_TMR_N-1:0]    tmr_sub_tap_src_i,
  input  wire [`CMWC_SIO_N-1:0]    sio_irq_i,
  input  wire [`CMWC_SIO_N-1:0]    sio_ext_clk_i,
  input  wire [`CMWC_PORT_W-1:0]   port_level_i,
  // control bit read-back
  output wire                      div8_select_o,
  output wire                      main_osc_stop_o,
  output wire                      sub_osc_enable_o,
  output wire                      sub_cpu_source_select_o,
  output wire                      onchip_source_select_o,
  output wire                      pll_cpu_select_o,
  output wire [1:0]                cpu_divide_ratio_o,
  output wire                      wait_periph_clock_stop_o,
  output wire                      watchdog_onchip_source_o,
  output wire                      pll_run_enable_o,
  output wire [3:0]                onchip_freq_select_o,
  // oscillator controls
  output wire                      main_osc_run_o,
  output wire                      sub_osc_run_o,
  output wire                      onchip_osc_run_o,
  // clock enables
  output reg                       cpu_clk_en_o,
  output reg                       wdt_clk_en_o,
  output reg  [3:0]                periph_clk_en_o,
  output reg  [3:0]                sio_clk_en_o,
  output reg                       converter_clock_en_o,
  output reg                       sub_clock_tap_en_o,
  // status
  output wire [`CMWC_MODE_W-1:0]   mode_o,
  output wire                      wait_o,
  output reg  [`CMWC_PORT_W-1:0]   port_level_o
);

  // wait state machine, one-hot
  localparam [2:0] ST_RUN    = 3'h1;
  localparam [2:0] ST_WAIT   = 3'h2;
  localparam [2:0] ST_RESUME = 3'h4;

  reg        div8_q;
  reg        main_stop_q;
  reg        sub_en_q;
  reg        sub_cpu_q;
  reg        onchip_src_q;
  reg        pll_cpu_q;
  reg  [1:0] ratio_q;
  reg        wait_stop_q;
  reg        wdt_onchip_q;
  reg        pll_run_q;
  reg  [3:0] freq_q;
  reg  [2:0] state_q;
  reg  [2:0] state_d;
  reg  [`CMWC_MODE_W-1:0] mode;
  reg        cpu_src_tick;
  reg  [4:0] cpu_mask;
  reg        per_src_tick;
  reg        div8_d;
  wire       cpu_tick;
  wire [3:0] per_tick;
  wire       sub_tap_tick;
  wire       wake;
  wire       wr_ok;
  wire [`CMWC_TMR_N-1:0] tmr_wake;
  wire [`CMWC_SIO_N-1:0] sio_wake;

  // mode from control bits alone; illegal sets fall back to a live source
  always @* begin
    mode = {`CMWC_MODE_W{1'b0}};
    if (sub_cpu_q && sub_en_q) begin
      if (main_stop_q)
        mode[`CMWC_MODE_LOWPWR] = 1'b1; // RULE1
      else
        mode[`CMWC_MODE_LOW] = 1'b1; // RULE2
    end else if (onchip_src_q && !sub_cpu_q) begin
      if (main_stop_q)
        mode[`CMWC_MODE_ONCHIP_LP] = 1'b1; // RULE9
      else
        mode[`CMWC_MODE_ONCHIP] = 1'b1; // RULE9
    end else if (main_stop_q || sub_cpu_q) begin
      // main stopped or sub off: on-chip is the safe pick
      mode[`CMWC_MODE_ONCHIP_LP] = 1'b1; // RULE24
    end else if (pll_cpu_q && pll_run_q) begin
      mode[`CMWC_MODE_PLL] = 1'b1; // RULE8
    end else if (div8_q || ratio_q != `CMWC_RATIO_DIV1) begin
      mode[`CMWC_MODE_MEDIUM] = 1'b1; // RULE8
    end else begin
      // pll selected but not running is a dead clock; stay on main
      mode[`CMWC_MODE_HIGH] = 1'b1; // RULE24
    end
  end

  // cpu divide mask; div8 select overrides the ratio
  always @* begin
    if (div8_q)
      cpu_mask = `CMWC_MASK_DIV8;
    else begin
      case (ratio_q)
        `CMWC_RATIO_DIV1: cpu_mask = `CMWC_MASK_DIV1;
        `CMWC_RATIO_DIV2: cpu_mask = `CMWC_MASK_DIV2;
        `CMWC_RATIO_DIV4: cpu_mask = `CMWC_MASK_DIV4;
        default:          cpu_mask = `CMWC_MASK_DIV16;
      endcase
    end
  end

  // cpu and peripheral source selection per mode
  always @* begin
    cpu_src_tick = 1'b0;
    per_src_tick = 1'b0;
    if (mode[`CMWC_MODE_LOW] || mode[`CMWC_MODE_LOWPWR]) begin
      cpu_src_tick = sub_tick_i; // RULE1
      if (mode[`CMWC_MODE_LOW])
        per_src_tick = onchip_src_q ? onchip_tick_i : main_tick_i;
    end else if (mode[`CMWC_MODE_ONCHIP] || mode[`CMWC_MODE_ONCHIP_LP]) begin
      cpu_src_tick = onchip_tick_i; // RULE4
      per_src_tick = onchip_tick_i; // RULE7
    end else if (mode[`CMWC_MODE_PLL]) begin
      cpu_src_tick = pll_tick_i; // RULE8
      per_src_tick = pll_tick_i;
    end else begin
      cpu_src_tick = main_tick_i; // RULE8
      per_src_tick = main_tick_i;
    end
  end

  // pll and sub clock undivided; main and on-chip use the mask
  cmwc_tick_div u_cpu_div (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .src_tick_i (cpu_src_tick),
    .mask_i     ((mode[`CMWC_MODE_PLL] | mode[`CMWC_MODE_LOW] | mode[`CMWC_MODE_LOWPWR]) ?
                 `CMWC_MASK_DIV1 : cpu_mask),
    .tick_o     (cpu_tick)
  );

  // peripheral taps divide by 1, 2, 8 and 32
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_per
      cmwc_tick_div u_per_div (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .src_tick_i (per_src_tick),
        .mask_i     ((gi == 0) ? `CMWC_MASK_DIV1 : (gi == 1) ? `CMWC_MASK_DIV2 :
                     (gi == 2) ? `CMWC_MASK_DIV8 : `CMWC_MASK_DIV32),
        .tick_o     (per_tick[gi])
      );
    end
  endgenerate

  // sub clock tap runs whenever the sub oscillator does, wait or not
  cmwc_tick_div u_sub_div (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .src_tick_i (sub_tick_i & sub_en_q),
    .mask_i     (`CMWC_MASK_DIV32),
    .tick_o     (sub_tap_tick)
  );

  // timer and serial wake qualification per channel
  generate
    for (gi = 0; gi < `CMWC_TMR_N; gi = gi + 1) begin : g_tmr
      assign tmr_wake[gi] = tmr_irq_i[gi] &
                            (!wait_stop_q | tmr_event_mode_i[gi] | tmr_sub_tap_src_i[gi]); // RULE19
    end
    for (gi = 0; gi < `CMWC_SIO_N; gi = gi + 1) begin : g_sio
      assign sio_wake[gi] = sio_irq_i[gi] & (!wait_stop_q | sio_ext_clk_i[gi]); // RULE20
    end
  endgenerate

  // internally clocked sources count only while peripheral clocks stay on
  assign wake = nmi_i | key_irq_i | ext_pin_irq_i | (|tmr_wake) | (|sio_wake) | // RULE18
                (!wait_stop_q & (i2c_irq_i | timer_s_irq_i |
                                 (adc_irq_i & adc_single_mode_i))); // RULE17

  // writes land only while the cpu runs
  assign wr_ok = cc_wr_i & state_q[0];

  // div8 select: forced on entry to low power from low-speed mode, frozen while there
  always @* begin
    div8_d = div8_q;
    if (wr_ok) begin
      if (mode[`CMWC_MODE_LOW] && wr_main_osc_stop_i)
        div8_d = 1'b1; // RULE2
      else if (!mode[`CMWC_MODE_LOWPWR])
        div8_d = wr_div8_select_i; // RULE3
    end
  end

  // control bits, held through wait so wake resumes as before halt
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      div8_q       <= `CMWC_RST_DIV8;
      main_stop_q  <= `CMWC_RST_MAIN_STOP;
      sub_en_q     <= `CMWC_RST_SUB_EN;
      sub_cpu_q    <= `CMWC_RST_SUB_CPU;
      onchip_src_q <= `CMWC_RST_ONCHIP_SRC;
      pll_cpu_q    <= `CMWC_RST_PLL_CPU;
      ratio_q      <= `CMWC_RST_RATIO;
      wait_stop_q  <= `CMWC_RST_WAIT_STOP;
      wdt_onchip_q <= `CMWC_RST_WDT_ONCHIP;
      pll_run_q    <= `CMWC_RST_PLL_RUN;
      freq_q       <= `CMWC_RST_FREQ;
    end else if (wr_ok) begin // RULE22
      div8_q       <= div8_d;
      main_stop_q  <= wr_main_osc_stop_i;
      sub_en_q     <= wr_sub_osc_enable_i;
      sub_cpu_q    <= wr_sub_cpu_source_select_i;
      onchip_src_q <= wr_onchip_source_select_i;
      pll_cpu_q    <= wr_pll_cpu_select_i;
      ratio_q      <= wr_cpu_divide_ratio_i;
      wait_stop_q  <= wr_wait_periph_clock_stop_i;
      wdt_onchip_q <= wr_watchdog_onchip_source_i;
      pll_run_q    <= wr_pll_run_enable_i;
      freq_q       <= wr_onchip_freq_select_i; // RULE5
    end
  end

  // wait sequencing
  always @* begin
    case (state_q)
      ST_RUN:    state_d = halt_i ? ST_WAIT : ST_RUN; // RULE12
      ST_WAIT:   state_d = wake ? ST_RESUME : ST_WAIT; // RULE15
      // release only on a divided cpu tick so the first cpu pulse is a whole period
      ST_RESUME: state_d = cpu_tick ? ST_RUN : ST_RESUME; // RULE23
      default:   state_d = ST_RUN;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= ST_RUN; // RULE15
    end else begin
      state_q <= state_d;
    end
  end

  // port levels follow the core while running and freeze across wait
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      port_level_o <= {`CMWC_PORT_W{1'b0}};
    end else if (state_q[0] && !halt_i) begin
      port_level_o <= port_level_i; // RULE14
    end
  end

  // registered clock enables
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      cpu_clk_en_o         <= 1'b0;
      wdt_clk_en_o         <= 1'b0;
      periph_clk_en_o      <= 4'h0;
      sio_clk_en_o         <= 4'h0;
      converter_clock_en_o <= 1'b0;
      sub_clock_tap_en_o   <= 1'b0;
    end else begin
      cpu_clk_en_o         <= cpu_tick & state_q[0]; // RULE10
      wdt_clk_en_o         <= wdt_onchip_q ? onchip_tick_i : (cpu_tick & state_q[0]); // RULE10
      periph_clk_en_o      <= (wait_stop_q && !state_q[0]) ? 4'h0 : per_tick; // RULE11
      sio_clk_en_o         <= (wait_stop_q && !state_q[0]) ? 4'h0 : per_tick; // RULE11
      converter_clock_en_o <= per_src_tick & !(wait_stop_q && !state_q[0]); // RULE11
      sub_clock_tap_en_o   <= sub_tap_tick; // RULE11
    end
  end

  // oscillator run controls; wait changes none of them
  assign main_osc_run_o   = !main_stop_q; // RULE1
  assign sub_osc_run_o    = sub_en_q;
  assign onchip_osc_run_o = onchip_src_q | wdt_onchip_q | mode[`CMWC_MODE_ONCHIP_LP]; // RULE24

  assign div8_select_o            = div8_q;
  assign main_osc_stop_o          = main_stop_q;
  assign sub_osc_enable_o         = sub_en_q;
  assign sub_cpu_source_select_o  = sub_cpu_q;
  assign onchip_source_select_o   = onchip_src_q;
  assign pll_cpu_select_o         = pll_cpu_q;
  assign cpu_divide_ratio_o       = ratio_q;
  assign wait_periph_clock_stop_o = wait_stop_q;
  assign watchdog_onchip_source_o = wdt_onchip_q;
  assign pll_run_enable_o         = pll_run_q;
  assign onchip_freq_select_o     = freq_q; // RULE5
  assign mode_o                   = mode;
  assign wait_o                   = !state_q[0];

endmodule // cmwc_clock_ctrl

// ### test/cmwc_osc_model.sv
// oscillator model: main, sub, on-chip and pll tick enables.
// assumes ticks are sampled at the rising core_clk_i edge.
`timescale 1ns/1ns
module cmwc_osc_model #(
  parameter int MP = 3,
  parameter int SP = 8,
  parameter int OP = 2
) (
  input  wire core_clk_i,
  input  wire main_run_i,
  input  wire sub_run_i,
  input  wire onchip_run_i,
  input  wire pll_run_i,
  output wire main_tick_o,
  output wire sub_tick_o,
  output wire onchip_tick_o,
  output wire pll_tick_o
);
  int mc_q = 0;
  int sc_q = 0;
  int oc_q = 0;

  // sources keep running in wait; only their run controls stop them
  always @(posedge core_clk_i) begin
    mc_q <= (mc_q >= MP - 1) ? 0 : mc_q + 1;
    sc_q <= (sc_q >= SP - 1) ? 0 : sc_q + 1;
    oc_q <= (oc_q >= OP - 1) ? 0 : oc_q + 1;
  end

  // a stopped oscillator gives no ticks
  assign main_tick_o   = main_run_i && (mc_q == 0);
  assign sub_tick_o    = sub_run_i && (sc_q == 0);
  assign onchip_tick_o = onchip_run_i && (oc_q == 0);
  assign pll_tick_o    = pll_run_i;
endmodule // cmwc_osc_model

// ### test/cmwc_chk_sva.sv
// checker: properties on the controller ports.
// assumes one core_clk_i domain, sync active-high srst_i.
`timescale 1ns/1ns
`include "cmwc_map.vh"
module cmwc_chk (
  input wire                     core_clk_i,
  input wire                     srst_i,
  input wire                     cc_wr_i,
  input wire                     wr_main_osc_stop_i,
  input wire                     halt_i,
  input wire                     nmi_i,
  input wire                     div8_select_o,
  input wire                     main_osc_stop_o,
  input wire                     sub_cpu_source_select_o,
  input wire                     onchip_source_select_o,
  input wire                     pll_cpu_select_o,
  input wire [1:0]               cpu_divide_ratio_o,
  input wire                     wait_periph_clock_stop_o,
  input wire                     watchdog_onchip_source_o,
  input wire                     main_osc_run_o,
  input wire                     cpu_clk_en_o,
  input wire                     wdt_clk_en_o,
  input wire [3:0]               periph_clk_en_o,
  input wire [3:0]               sio_clk_en_o,
  input wire                     converter_clock_en_o,
  input wire [`CMWC_MODE_W-1:0]  mode_o,
  input wire                     wait_o,
  input wire [`CMWC_PORT_W-1:0]  port_level_o
);
  default clocking dcb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  // mode decode; enables lag one cycle, hence the $past guards
  lowpwr_entry_a: assert property (cc_wr_i && !wait_o && mode_o[3] && wr_main_osc_stop_i
    |=> mode_o[4] && div8_select_o) else $error("low power entry");
  lowpwr_clocks_a: assert property (mode_o[4] && $past(mode_o[4])
    |-> !main_osc_run_o && !(|{periph_clk_en_o, sio_clk_en_o, converter_clock_en_o}))
    else $error("clock alive in low power");
  pll_decode_a: assert property (mode_o[0] |-> pll_cpu_select_o && !onchip_source_select_o
    && cpu_divide_ratio_o == 2'h0 && !div8_select_o) else $error("pll mode with bad bits");
  onchip_decode_a: assert property (mode_o[5] |-> onchip_source_select_o
    && !sub_cpu_source_select_o && !main_osc_stop_o) else $error("on-chip mode with bad bits");
  mode_onehot_a: assert property ($onehot(mode_o)) else $error("mode not one-hot");

  // wait entry, gating, hold and exit
  halt_entry_a: assert property (!wait_o && halt_i |=> wait_o) else $error("halt not taken");
  wait_clocks_a: assert property (wait_o && $past(wait_o)
    |-> !cpu_clk_en_o && (watchdog_onchip_source_o || !wdt_clk_en_o)) else $error("cpu clock in wait");
  wait_gate_a: assert property (wait_o && $past(wait_o) && wait_periph_clock_stop_o
    |-> !(|{periph_clk_en_o, sio_clk_en_o, converter_clock_en_o})) else $error("periph clock in wait");
  port_hold_a: assert property (wait_o && $past(wait_o)
    |-> $stable(port_level_o)) else $error("port level moved in wait");
  nmi_wake_a: assert property (wait_o && nmi_i |-> ##[1:600] !wait_o) else $error("nmi no wake");
  wait_frozen_a: assert property (wait_o |=> $stable(mode_o) && $stable(cpu_divide_ratio_o)
    && $stable(div8_select_o)) else $error("setting moved in wait");

  // main scenarios reached
  cover property (!wait_o && halt_i);
  cover property (mode_o[4]);
  cover property ($fell(wait_o));
endmodule // cmwc_chk

// ### test/tb_top.sv
// bench top: controller, oscillator model, checker, directed tests.
// assumes one 250 MHz core clock; inputs change at the falling edge.
`timescale 1ns/1ns
`include "cmwc_map.vh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  $display("MISMATCH %s expected %0h seen %0h", n, e, s); num_errors++; end end
module tb_top;
  localparam int MP = 3;
  localparam int SP = 8;
  localparam int OP = 2;
  localparam int dv [5] = '{1, 2, 4, 16, 8};
  logic        core_clk_i = 1'h0;
  logic        srst_i     = 1'h1;
  logic        cc_wr_i    = 1'h0;
  logic        halt_i     = 1'h0;
  logic [14:0] wr_v       = 15'h0000;
  logic [10:0] sv         = 11'h000;
  logic [15:0] port_in    = 16'h0000;
  wire         mt, st, ot, pt, m_run, s_run, o_run, p_run, div8, cpu, wdt, conv, tap, wait_o;
  wire [1:0]   ratio;
  wire [3:0]   freq, per, sio;
  wire [6:0]   mode;
  wire [15:0]  port_out;
  int          num_errors  = 0;
  int          checks_done = 0;

  // 4 ns period
  always #2 core_clk_i = ~core_clk_i;

  // sources: [0]i2c [1]timer s [2]adc [3]timer ch0 [4]serial ch0 [5]key [6]pin
  // [7]timer ch3 event [8]timer ch4 sub tap [9]serial ch1 external [10]nmi
  cmwc_clock_ctrl dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .cc_wr_i(cc_wr_i),
    .wr_div8_select_i(wr_v[14]), .wr_main_osc_stop_i(wr_v[13]), .wr_sub_osc_enable_i(wr_v[12]),
    .wr_sub_cpu_source_select_i(wr_v[11]), .wr_onchip_source_select_i(wr_v[10]),
    .wr_pll_cpu_select_i(wr_v[9]), .wr_cpu_divide_ratio_i(wr_v[8:7]),
    .wr_wait_periph_clock_stop_i(wr_v[6]), .wr_watchdog_onchip_source_i(wr_v[5]),
    .wr_pll_run_enable_i(wr_v[4]), .wr_onchip_freq_select_i(wr_v[3:0]),
    .main_tick_i(mt), .sub_tick_i(st), .onchip_tick_i(ot), .pll_tick_i(pt), .halt_i(halt_i),
    .nmi_i(sv[10]), .key_irq_i(sv[5]), .ext_pin_irq_i(sv[6]), .i2c_irq_i(sv[0]),
    .timer_s_irq_i(sv[1]), .adc_irq_i(sv[2]), .adc_single_mode_i(1'h1),
    .tmr_irq_i({3'h0, sv[8:7], 2'h0, sv[3]}), .tmr_event_mode_i(8'h08), .tmr_sub_tap_src_i(8'h10),
    .sio_irq_i({3'h0, sv[9], sv[4]}), .sio_ext_clk_i(5'h02), .port_level_i(port_in),
    .div8_select_o(div8), .main_osc_stop_o(), .sub_osc_enable_o(), .sub_cpu_source_select_o(),
    .onchip_source_select_o(), .pll_cpu_select_o(), .cpu_divide_ratio_o(ratio),
    .wait_periph_clock_stop_o(), .watchdog_onchip_source_o(), .pll_run_enable_o(p_run),
    .onchip_freq_select_o(freq), .main_osc_run_o(m_run), .sub_osc_run_o(s_run),
    .onchip_osc_run_o(o_run), .cpu_clk_en_o(cpu), .wdt_clk_en_o(wdt), .periph_clk_en_o(per),
    .sio_clk_en_o(sio), .converter_clock_en_o(conv), .sub_clock_tap_en_o(tap), .mode_o(mode),
    .wait_o(wait_o), .port_level_o(port_out));

  cmwc_osc_model #(.MP(MP), .SP(SP), .OP(OP)) osc (
    .core_clk_i(core_clk_i), .main_run_i(m_run), .sub_run_i(s_run), .onchip_run_i(o_run),
    .pll_run_i(p_run), .main_tick_o(mt), .sub_tick_o(st), .onchip_tick_o(ot), .pll_tick_o(pt));

  // pack write fields in port order
  function automatic logic [14:0] wv(logic d8, ms, se, sc, oc, pl, logic [1:0] r, logic ps, wd, pr,
                                     logic [3:0] f);
    return {d8, ms, se, sc, oc, pl, r, ps, wd, pr, f};
  endfunction

  // 0 cpu, 1 any peripheral, 2 sub tap, 3 watchdog
  function automatic logic pick(int s);
    case (s)
      0: return cpu;
      1: return |{per, sio, conv};
      2: return tap;
      default: return wdt;
    endcase
  endfunction

  task automatic cyc(int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // one-cycle write strobe, then a cycle for read-back
  task automatic wr(logic [14:0] v);
    @(negedge core_clk_i);
    wr_v = v;
    cc_wr_i = 1'h1;
    cyc(1);
    cc_wr_i = 1'h0;
    cyc(1);
  endtask

  task automatic cnt(int s, int n, output int c);
    c = 0;
    repeat (n) begin
      cyc(1);
      c += (pick(s) === 1'h1);
    end
  endtask

  // first gap after a change may be short, so the second gap is judged
  task automatic chk_per(int s, int e);
    int p;
    repeat (2) begin
      p = 0;
      do begin
        cyc(1);
        p++;
      end while (pick(s) !== 1'h1 && p < 600);
    end
    `CHK("period", e, p)
  endtask

  task automatic halt;
    @(negedge core_clk_i);
    halt_i = 1'h1;
    cyc(1);
    halt_i = 1'h0;
    `CHK("enter wait", 1'h1, wait_o)
  endtask

  task automatic wake(logic e);
    int t;
    t = 0;
    while (wait_o !== 1'h0 && t < 300) begin
      cyc(1);
      t++;
    end
    `CHK("wake", e, wait_o === 1'h0)
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    int c;
    int i;
    cyc(12);
    srst_i = 1'h0;
    `CHK("reset mode", 7'h20, mode)
    `CHK("reset ratio", 2'h3, ratio)
    chk_per(0, 16 * OP);
    // every divide on on-chip with div8 last, then main with div8 first
    for (int oc = 1; oc >= 0; oc--) begin
      for (int j = 0; j < 5; j++) begin
        i = oc ? j : (j + 4) % 5;
        wr(wv(i == 4, 0, 0, 0, oc[0], 0, 2'(i), 0, 0, 0, 4'(i + 5)));
        `CHK("freq", 4'(i + 5), freq)
        `CHK("mode", oc ? 7'h20 : (i == 0 ? 7'h02 : 7'h04), mode)
        chk_per(0, dv[i] * (oc ? OP : MP));
      end
      chk_per(1, oc ? OP : MP);
    end
    wr(wv(0, 0, 0, 0, 0, 0, 2'h0, 0, 0, 1, 4'h0));
    wr(wv(0, 0, 0, 0, 0, 1, 2'h0, 0, 0, 1, 4'h0));
    `CHK("pll mode", 7'h01, mode)
    chk_per(0, 1);
    wr(wv(0, 0, 1, 0, 0, 0, 2'h0, 0, 0, 0, 4'h0));
    `CHK("high mode", 7'h02, mode)
    wr(wv(0, 0, 1, 1, 0, 0, 2'h0, 0, 0, 0, 4'h0));
    `CHK("low mode", 7'h08, mode)
    chk_per(0, SP);
    wr(wv(0, 1, 1, 1, 0, 0, 2'h0, 0, 0, 0, 4'h0));
    `CHK("lowpwr mode", 7'h10, mode)
    `CHK("div8 forced", 1'h1, div8)
    `CHK("main stopped", 1'h0, m_run)
    cnt(1, 50, c);
    `CHK("lowpwr periph", 0, c)
    chk_per(2, 32 * SP);
    wr(wv(1, 0, 1, 1, 0, 0, 2'h0, 0, 0, 0, 4'h0));
    wr(wv(1, 0, 1, 0, 0, 0, 2'h0, 0, 0, 0, 4'h0));
    `CHK("medium div8", 7'h04, mode)
    // wait, clocks on; a write in wait must not land
    port_in = 16'hA5C3;
    cyc(2);
    halt();
    port_in = 16'h5A3C;
    wr(wv(0, 0, 0, 0, 1, 0, 2'h0, 0, 0, 0, 4'h0));
    cnt(0, 60, c);
    `CHK("cpu in wait", 0, c)
    cnt(3, 60, c);
    `CHK("wdt in wait", 0, c)
    `CHK("port hold", 16'hA5C3, port_out)
    sv[3] = 1'h1;
    wake(1'h1);
    sv[3] = 1'h0;
    `CHK("resume mode", 7'h04, mode)
    chk_per(0, 8 * MP);
    // wait, clocks stopped: only external sources wake
    wr(wv(1, 0, 1, 0, 1, 0, 2'h0, 1, 1, 0, 4'h0));
    halt();
    cnt(1, 60, c);
    `CHK("periph stopped", 0, c)
    cnt(3, 60, c);
    `CHK("wdt on-chip", 1, c > 0)
    cnt(2, 300, c);
    `CHK("tap runs", 1, c > 0)
    for (int k = 0; k < 11; k++) begin
      if (wait_o !== 1'h1) halt();
      sv[k] = 1'h1;
      wake(k > 4);
      sv[k] = 1'h0;
    end
    test_done();
  end

  // hang guard; the sequence needs under 10000 cycles
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
endmodule // tb_top

bind cmwc_clock_ctrl cmwc_chk chk (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .cc_wr_i(cc_wr_i), .wr_main_osc_stop_i(wr_main_osc_stop_i),
  .halt_i(halt_i), .nmi_i(nmi_i), .div8_select_o(div8_select_o), .main_osc_stop_o(main_osc_stop_o),
  .sub_cpu_source_select_o(sub_cpu_source_select_o), .onchip_source_select_o(onchip_source_select_o),
  .pll_cpu_select_o(pll_cpu_select_o), .cpu_divide_ratio_o(cpu_divide_ratio_o),
  .wait_periph_clock_stop_o(wait_periph_clock_stop_o), .watchdog_onchip_source_o(watchdog_onchip_source_o),
  .main_osc_run_o(main_osc_run_o), .cpu_clk_en_o(cpu_clk_en_o), .wdt_clk_en_o(wdt_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .sio_clk_en_o(sio_clk_en_o), .converter_clock_en_o(converter_clock_en_o),
  .mode_o(mode_o), .wait_o(wait_o), .port_level_o(port_level_o));
